// File: hdl/osc_ctrl_pkg.sv
// Purpose: shared constants and types for the oscillator start-up delay control
// Assumes: one 25 MHz reference clock; oscillator edges arrive as enable pulses
// Notes: oscillator mode codes are local encodings of the configuration field
// Behaviour
// - In the three crystal modes a start-up count of 1024 oscillator cycles runs after power-on (after the power-up timer) or wake from sleep.
// - While the start-up count runs, the program counter is frozen and execution is suspended.
// - A wake from sleep skips the count when low-gain crystal mode, secondary oscillator enable 1, clock select 0 and the running flag 1 all hold.
// - The watchdog counter is held in reset during the start-up count and may count once it has expired.
// - A 10 us internal delay is inserted for internal, external-logic or RC sources on wake or power-on, for the crystal special case, and for a slow-internal to external-logic or RC switch.
// - A switch from an internal oscillator to any crystal mode completes a 1024-cycle start-up count before the new clock is used.
// - External logic clock mode takes the clock from the oscillator input pin and frees the second oscillator pin for general use.
// - External logic clock mode disables the start-up timer, so no count follows power-on or wake.
// - The logic is fully static, so a stopped clock halts it with all state kept and it resumes where it stopped.
// - The crystal mode selects amplifier gain: lowest for low, intermediate for medium, highest for high.
// - Low-gain crystal mode with the secondary oscillator enabled clocks the system and the secondary timer from one shared oscillator.
// - The clock select bit chooses the system clock between the external source and the internal oscillators.
// - Two internal sources exist: a fast one at 8 MHz and a slow one near 31 kHz.
// - With clock select 0 the oscillator mode comes from the configuration field, and the running flag reads 1 while running from the primary clock.
package osc_ctrl_pkg;

    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned STARTUP_CYCLES  = 1024;
    localparam int unsigned BIAS_DELAY_NS   = 10_000;
    localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
    // least time: round up
    localparam int unsigned BIAS_DELAY_CYC  = (BIAS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FAST_OSC_HZ     = 8_000_000;
    localparam int unsigned SLOW_OSC_HZ     = 31_000;

    // oscillator configuration field encodings
    typedef enum logic [2:0] {
        LOW_GAIN_CRYSTAL_MODE    = 3'h0,
        MEDIUM_GAIN_CRYSTAL_MODE = 3'h1,
        HIGH_GAIN_CRYSTAL_MODE   = 3'h2,
        EXTERNAL_LOGIC_CLOCK_MODE = 3'h3,
        INTERNAL_OSC_NOCLKOUT    = 3'h4,
        INTERNAL_OSC_CLKOUT      = 3'h5,
        RESISTOR_CAPACITOR_MODE  = 3'h6,
        RESISTOR_CAPACITOR_CLKOUT = 3'h7
    } osc_mode_t;

    // amplifier gain codes
    localparam logic [1:0] GAIN_OFF    = 2'h0;
    localparam logic [1:0] GAIN_LOW    = 2'h1;
    localparam logic [1:0] GAIN_MEDIUM = 2'h2;
    localparam logic [1:0] GAIN_HIGH   = 2'h3;

    // system clock source select codes
    localparam logic [1:0] SRC_PRIMARY   = 2'h0;
    localparam logic [1:0] SRC_FAST_INT  = 2'h1;
    localparam logic [1:0] SRC_SLOW_INT  = 2'h2;

    // events that start a delay
    typedef struct packed {
        logic power_on;
        logic wake;
        logic switch_req;
    } start_events_t;

    // status bundle
    typedef struct packed {
        logic       execution_enable;
        logic       startup_busy;
        logic       bias_busy;
        logic       primary_clock_running_flag;
    } osc_status_t;

endpackage

// File: hdl/startup_counter.sv
// Purpose: counts oscillator-cycle enables up to a terminal count
// Assumes: start pulse and cycle enable are synchronous to clk_in
// Notes: restarts from zero on every start pulse
`timescale 1ns/1ps
`default_nettype none
module startup_counter #(
    parameter int unsigned TERMINAL = 1024
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic start_in,
    input  wire logic cycle_en_in,
    output logic      busy_out,
    output logic      done_out
);
    localparam int unsigned CW = $clog2(TERMINAL + 1);
    localparam logic [CW-1:0] TERM = CW'(TERMINAL);

    initial begin
        if (TERMINAL < 1) $error("terminal count must be at least one");
    end

    logic [CW-1:0] count_reg;
    logic          busy_reg;
    logic          done_reg;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_reg <= '0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else if (start_in) begin
            count_reg <= '0;
            busy_reg  <= 1'b1;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (busy_reg && cycle_en_in) begin
                if (count_reg == TERM - 1'b1) begin
                    count_reg <= '0;
                    busy_reg  <= 1'b0;
                    done_reg  <= 1'b1;
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end
        end
    end

    assign busy_out = busy_reg;
    assign done_out = done_reg;
endmodule // startup_counter
`default_nettype wire

// File: hdl/osc_startup_ctrl.sv
// Purpose: selects system clock source and holds execution through start-up delays
// Assumes: oscillator and watchdog edges come in as one-cycle enables on ref_clk_in
// Notes: a stopped reference clock freezes every register in place
`timescale 1ns/1ps
`default_nettype none
module osc_startup_ctrl #(
    parameter int unsigned STARTUP_COUNT = osc_ctrl_pkg::STARTUP_CYCLES,
    parameter int unsigned BIAS_CYCLES   = osc_ctrl_pkg::BIAS_DELAY_CYC
) (
    input  wire logic                      ref_clk_in,
    input  wire logic                      rst_in,
    input  wire osc_ctrl_pkg::osc_mode_t   oscillator_config_field_in,
    input  wire logic                      system_clock_select_in,
    input  wire logic                      fast_select_in,
    input  wire logic                      secondary_osc_enable_in,
    input  wire logic                      powerup_timer_enable_in,
    input  wire logic                      powerup_timer_done_in,
    input  wire logic                      sleep_in,
    input  wire logic                      wake_in,
    input  wire logic                      oscillator_input_pin_in,
    input  wire logic                      osc_cycle_en_in,
    input  wire logic                      watchdog_enable_in,
    output logic                           execution_enable_out,
    output logic                           pc_freeze_out,
    output logic                           watchdog_counter_reset_out,
    output logic                           watchdog_count_en_out,
    output logic                           primary_clock_running_flag_out,
    output logic [1:0]                     system_clock_source_out,
    output logic [1:0]                     amplifier_gain_out,
    output logic                           second_osc_pin_gpio_out,
    output logic                           ext_clock_from_pin_out,
    output logic                           secondary_timer_shared_out,
    output osc_ctrl_pkg::osc_status_t      status_out
);
    initial begin
        if (STARTUP_COUNT < 1) $error("start-up count must be at least one");
        if (BIAS_CYCLES < 1) $error("bias delay must be at least one cycle");
    end

    typedef enum logic [2:0] {
        ST_POR_WAIT = 3'b000,
        ST_STARTUP  = 3'b001,
        ST_BIAS     = 3'b010,
        ST_RUN      = 3'b011,
        ST_SLEEP    = 3'b100
    } ctrl_state_t;

    ctrl_state_t state_reg;
    ctrl_state_t state_next;

    localparam int unsigned BW = $clog2(BIAS_CYCLES + 1);
    localparam logic [BW-1:0] BIAS_TERM = BW'(BIAS_CYCLES);

    logic [BW-1:0] bias_count_reg;
    logic          primary_running_reg;
    logic          special_case_reg;
    logic          prev_select_reg;
    logic [1:0]    prev_source_reg;
    logic          startup_start;
    logic          startup_busy;
    logic          startup_done;
    logic          bias_start;
    logic          bias_done;
    logic          is_crystal;
    logic          is_ext_logic;
    logic [1:0]    source_now;

    // mode decode
    assign is_crystal   = (oscillator_config_field_in == osc_ctrl_pkg::LOW_GAIN_CRYSTAL_MODE)
                       || (oscillator_config_field_in == osc_ctrl_pkg::MEDIUM_GAIN_CRYSTAL_MODE)
                       || (oscillator_config_field_in == osc_ctrl_pkg::HIGH_GAIN_CRYSTAL_MODE);
    assign is_ext_logic = (oscillator_config_field_in == osc_ctrl_pkg::EXTERNAL_LOGIC_CLOCK_MODE);

    always_comb begin
        if (!system_clock_select_in) begin
            source_now = osc_ctrl_pkg::SRC_PRIMARY;
        end else if (fast_select_in) begin
            source_now = osc_ctrl_pkg::SRC_FAST_INT;
        end else begin
            source_now = osc_ctrl_pkg::SRC_SLOW_INT;
        end
    end

    startup_counter #(
        .TERMINAL (STARTUP_COUNT)
    ) u_startup (
        .clk_in      (ref_clk_in),
        .rst_in      (rst_in),
        .start_in    (startup_start),
        .cycle_en_in (osc_cycle_en_in),
        .busy_out    (startup_busy),
        .done_out    (startup_done)
    );

    assign bias_done = (state_reg == ST_BIAS) && (bias_count_reg == BIAS_TERM - 1'b1);

    // next state and delay launch
    always_comb begin
        state_next    = state_reg;
        startup_start = 1'b0;
        bias_start    = 1'b0;
        unique case (state_reg)
            ST_POR_WAIT: begin
                if (!powerup_timer_enable_in || powerup_timer_done_in) begin
                    // crystal counts, external logic does not
                    if (is_crystal && !system_clock_select_in) begin
                        state_next    = ST_STARTUP;
                        startup_start = 1'b1;
                    end else begin
                        state_next = ST_BIAS;
                        bias_start = 1'b1;
                    end
                end
            end
            ST_STARTUP: begin
                if (startup_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_BIAS: begin
                if (bias_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (sleep_in) begin
                    state_next = ST_SLEEP;
                end else if (prev_select_reg && !system_clock_select_in && is_crystal) begin
                    state_next    = ST_STARTUP;
                    startup_start = 1'b1;
                end else if (prev_source_reg == osc_ctrl_pkg::SRC_SLOW_INT && !system_clock_select_in
                             && !is_crystal) begin
                    state_next = ST_BIAS;
                    bias_start = 1'b1;
                end
            end
            ST_SLEEP: begin
                if (wake_in) begin
                    if (is_crystal && !system_clock_select_in && !special_case_reg) begin
                        state_next    = ST_STARTUP;
                        startup_start = 1'b1;
                    end else begin
                        state_next = ST_BIAS;
                        bias_start = 1'b1;
                    end
                end
            end
            default: begin
                state_next = ST_POR_WAIT;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_reg <= ST_POR_WAIT;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in || bias_start || state_reg != ST_BIAS) begin
            bias_count_reg <= '0;
        end else begin
            bias_count_reg <= bias_count_reg + 1'b1;
        end
    end

    // capture special case at sleep entry
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            special_case_reg <= 1'b0;
        end else if (state_reg == ST_RUN && sleep_in) begin
            special_case_reg <= (oscillator_config_field_in == osc_ctrl_pkg::LOW_GAIN_CRYSTAL_MODE)
                             && secondary_osc_enable_in && !system_clock_select_in && primary_running_reg;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            primary_running_reg <= 1'b0;
        end else if (system_clock_select_in) begin
            primary_running_reg <= 1'b0;
        end else if (state_next == ST_RUN) begin
            primary_running_reg <= 1'b1;
        end
    end

    // previous selection for switch detection
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            prev_select_reg <= 1'b0;
            prev_source_reg <= osc_ctrl_pkg::SRC_PRIMARY;
        end else if (state_reg == ST_RUN) begin
            prev_select_reg <= system_clock_select_in;
            prev_source_reg <= source_now;
        end
    end

    assign execution_enable_out = (state_reg == ST_RUN);
    assign pc_freeze_out        = (state_reg != ST_RUN);

    assign watchdog_counter_reset_out = startup_busy;
    assign watchdog_count_en_out      = watchdog_enable_in && !startup_busy;

    assign primary_clock_running_flag_out = primary_running_reg;
    assign system_clock_source_out        = source_now;

    always_comb begin
        unique case (oscillator_config_field_in)
            osc_ctrl_pkg::LOW_GAIN_CRYSTAL_MODE:    amplifier_gain_out = osc_ctrl_pkg::GAIN_LOW;
            osc_ctrl_pkg::MEDIUM_GAIN_CRYSTAL_MODE: amplifier_gain_out = osc_ctrl_pkg::GAIN_MEDIUM;
            osc_ctrl_pkg::HIGH_GAIN_CRYSTAL_MODE:   amplifier_gain_out = osc_ctrl_pkg::GAIN_HIGH;
            default:                                amplifier_gain_out = osc_ctrl_pkg::GAIN_OFF;
        endcase
    end

    // pin use in external logic mode
    assign second_osc_pin_gpio_out = is_ext_logic;
    assign ext_clock_from_pin_out  = is_ext_logic && !system_clock_select_in && oscillator_input_pin_in;

    assign secondary_timer_shared_out = (oscillator_config_field_in == osc_ctrl_pkg::LOW_GAIN_CRYSTAL_MODE)
                                     && secondary_osc_enable_in;

    assign status_out = '{execution_enable:           (state_reg == ST_RUN),
                          startup_busy:               startup_busy,
                          bias_busy:                  (state_reg == ST_BIAS),
                          primary_clock_running_flag: primary_running_reg};
endmodule // osc_startup_ctrl
`default_nettype wire

// File: bench/osc_ctrl_properties.sv
// Purpose: port-level checks of the oscillator start-up control
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every osc_startup_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl_properties #(
    parameter int unsigned STARTUP_COUNT = 1024
) (
    input wire logic                    ref_clk_in,
    input wire logic                    rst_in,
    input wire osc_ctrl_pkg::osc_mode_t oscillator_config_field_in,
    input wire logic                    system_clock_select_in,
    input wire logic                    fast_select_in,
    input wire logic                    secondary_osc_enable_in,
    input wire logic                    watchdog_enable_in,
    input wire logic                    osc_cycle_en_in,
    input wire logic                    execution_enable_out,
    input wire logic                    pc_freeze_out,
    input wire logic                    watchdog_counter_reset_out,
    input wire logic                    watchdog_count_en_out,
    input wire logic                    primary_clock_running_flag_out,
    input wire logic [1:0]              system_clock_source_out,
    input wire logic [1:0]              amplifier_gain_out,
    input wire logic                    second_osc_pin_gpio_out,
    input wire logic                    secondary_timer_shared_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // oscillator pulses taken while the count holds the watchdog
    logic [31:0] pulse_cnt_reg;
    always_ff @(posedge ref_clk_in) begin
        pulse_cnt_reg <= watchdog_counter_reset_out ? pulse_cnt_reg + 32'(osc_cycle_en_in) : 32'h0;
    end
    sequence count_done;
        $fell(watchdog_counter_reset_out);
    endsequence
    count_len_a: assert property (count_done |-> pulse_cnt_reg == STARTUP_COUNT)
        else $error("start-up count ended at the wrong pulse");
    run_after_a: assert property (count_done |-> ##[0:2] execution_enable_out)
        else $error("execution not released after count");
    hold_exec_a: assert property (watchdog_counter_reset_out |-> !execution_enable_out)
        else $error("execution during start-up count");
    freeze_inv_a: assert property (pc_freeze_out != execution_enable_out)
        else $error("program counter freeze disagrees");
    wd_gate_a: assert property (watchdog_count_en_out == (watchdog_enable_in && !watchdog_counter_reset_out))
        else $error("watchdog count enable wrong");
    gain_map_a: assert property (amplifier_gain_out == (oscillator_config_field_in == 3'h0 ? 2'h1 :
        oscillator_config_field_in == 3'h1 ? 2'h2 : oscillator_config_field_in == 3'h2 ? 2'h3 : 2'h0))
        else $error("amplifier gain wrong");
    gpio_free_a: assert property (second_osc_pin_gpio_out == (oscillator_config_field_in == 3'h3))
        else $error("second pin release wrong");
    ext_nocount_a: assert property (oscillator_config_field_in == 3'h3 && $stable(oscillator_config_field_in)
        |-> !$rose(watchdog_counter_reset_out)) else $error("count started in external clock mode");
    shared_osc_a: assert property (secondary_timer_shared_out ==
        (oscillator_config_field_in == 3'h0 && secondary_osc_enable_in)) else $error("shared oscillator wrong");
    src_sel_a: assert property (system_clock_source_out == (!system_clock_select_in ? 2'h0 :
        fast_select_in ? 2'h1 : 2'h2)) else $error("clock source wrong");
    flag_run_a: assert property ($rose(execution_enable_out) && !system_clock_select_in
        |-> ##[0:1] primary_clock_running_flag_out) else $error("running flag not set");
endmodule // osc_ctrl_properties
bind osc_startup_ctrl osc_ctrl_properties #(.STARTUP_COUNT(STARTUP_COUNT)) u_props (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .oscillator_config_field_in(oscillator_config_field_in),
    .system_clock_select_in(system_clock_select_in), .fast_select_in(fast_select_in),
    .secondary_osc_enable_in(secondary_osc_enable_in), .watchdog_enable_in(watchdog_enable_in),
    .osc_cycle_en_in(osc_cycle_en_in), .execution_enable_out(execution_enable_out),
    .pc_freeze_out(pc_freeze_out), .watchdog_counter_reset_out(watchdog_counter_reset_out),
    .watchdog_count_en_out(watchdog_count_en_out), .system_clock_source_out(system_clock_source_out),
    .primary_clock_running_flag_out(primary_clock_running_flag_out), .amplifier_gain_out(amplifier_gain_out),
    .second_osc_pin_gpio_out(second_osc_pin_gpio_out), .secondary_timer_shared_out(secondary_timer_shared_out));
`default_nettype wire

// File: bench/osc_partner.sv
// Purpose: crystal or external clock source at the oscillator pins
// Assumes: one oscillator cycle every three reference cycles
// Notes: a stopped source holds its pin level and sends no pulses
`timescale 1ns/1ps
`default_nettype none
module osc_partner (
    input  wire logic clk_in,
    input  wire logic run_in,
    output logic      cycle_en_out,
    output logic      pin_out
);
    int unsigned phase;
    initial begin
        cycle_en_out = 1'b0;
        pin_out = 1'b0;
        phase = 0;
    end
    // pulse and pin edge per oscillator cycle, off the sampling edge
    always @(negedge clk_in) begin
        phase = run_in ? (phase + 1) % 3 : 0;
        cycle_en_out <= run_in && phase == 0;
        pin_out <= (run_in && phase == 0) ? ~pin_out : pin_out;
    end
endmodule // osc_partner
`default_nettype wire

// File: bench/testbench.sv
// Purpose: self-checking bench for the oscillator start-up control
// Assumes: short counts of 4 pulses and 2 bias cycles stand for the long ones
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int unsigned SC = 4;
    localparam int unsigned BC = 2;
    logic                      ref_clk, rst, sel, fast, sec, pwe, pwd, slp, wk, wden, run;
    logic                      osc_en, pin, exec, frz, wdr, wdce, flag, gpio, extclk, shared;
    logic [1:0]                src, gain;
    osc_ctrl_pkg::osc_mode_t   cfg;
    osc_ctrl_pkg::osc_status_t status;
    int                        errors, n_tests, pulses, wd_seen;
    int                        bm [3] = '{3, 4, 6};
    osc_partner u_osc (.clk_in(ref_clk), .run_in(run), .cycle_en_out(osc_en), .pin_out(pin));
    osc_startup_ctrl #(.STARTUP_COUNT(SC), .BIAS_CYCLES(BC)) u_dut (
        .ref_clk_in(ref_clk), .rst_in(rst), .oscillator_config_field_in(cfg), .system_clock_select_in(sel),
        .fast_select_in(fast), .secondary_osc_enable_in(sec), .powerup_timer_enable_in(pwe),
        .powerup_timer_done_in(pwd), .sleep_in(slp), .wake_in(wk), .oscillator_input_pin_in(pin),
        .osc_cycle_en_in(osc_en), .watchdog_enable_in(wden), .execution_enable_out(exec), .pc_freeze_out(frz),
        .watchdog_counter_reset_out(wdr), .watchdog_count_en_out(wdce), .primary_clock_running_flag_out(flag),
        .system_clock_source_out(src), .amplifier_gain_out(gain), .second_osc_pin_gpio_out(gpio),
        .ext_clock_from_pin_out(extclk), .secondary_timer_shared_out(shared), .status_out(status));
    // 25 MHz reference clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // pulses handed over and watchdog holds seen since the last clear
    always @(posedge ref_clk) begin
        pulses += int'(osc_en === 1'b1);
        wd_seen += int'(wdr === 1'b1);
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        if (errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // crystal gain model: low, medium, high, else off
    function automatic int m_gain(int m);
        return (m < 3) ? m + 1 : 0;
    endfunction
    task automatic run_wait(output int n);
        n = 0;
        while (exec !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    task automatic expect_count();
        int n;
        pulses = 0;
        run_wait(n);
        chk("count pulses", SC, (pulses == SC + 1) ? SC : pulses);
    endtask
    task automatic expect_bias();
        int n;
        wd_seen = 0;
        run_wait(n);
        chk("bias length ok", 1, n >= BC && n <= BC + 3);
        chk("no count", 0, wd_seen);
    endtask
    task automatic do_reset(input int m);
        @(negedge ref_clk);
        cfg = osc_ctrl_pkg::osc_mode_t'(m);
        rst = 1'b1;
        pwd = 1'b0;
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("held by powerup", pwe ? 2'h0 : 2'h2, {exec, wdr});
        pwd = 1'b1;
    endtask
    task automatic nap();
        slp = 1'b1;
        @(negedge ref_clk);
        slp = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("asleep", 0, exec);
        wk = 1'b1;
        @(negedge ref_clk);
        wk = 1'b0;
    endtask
    initial begin
        {rst, sel, fast, sec, slp, wk, wden, run, pwd, pwe} = 10'h201;
        cfg = osc_ctrl_pkg::LOW_GAIN_CRYSTAL_MODE;
        errors = 0;
        n_tests = 0;
        void'($urandom(32'h9bae5159));
        // crystal modes after power-on and after wake
        run = 1'b1;
        for (int m = 0; m < 3; m++) begin
            do_reset(m);
            expect_count();
            chk("primary flag", 1, flag);
            chk("status run", 4'h9, status);
            chk("gain", m_gain(m), gain);
            nap();
            expect_count();
        end
        // low-gain crystal sharing the secondary oscillator wakes without a count
        sec = 1'b1;
        do_reset(0);
        expect_count();
        chk("shared osc", 1, shared);
        nap();
        expect_bias();
        // external logic, internal and RC sources use the short delay
        sec = 1'b0;
        run = 1'b0;
        // power-up timer disabled: the short delay starts right after reset
        pwe = 1'b0;
        do_reset(4);
        pwe = 1'b1;
        foreach (bm[i]) begin
            run = (bm[i] == 3);
            do_reset(bm[i]);
            expect_bias();
            chk("pin freed", bm[i] == 3, gpio);
            repeat (3) begin
                @(negedge ref_clk);
                chk("pin clock", bm[i] == 3 && pin, extclk);
            end
            nap();
            expect_bias();
        end
        // slow internal back to RC, then to a crystal
        for (int m = 6; m >= 2; m -= 4) begin
            run = (m == 2);
            if (m == 2) do_reset(m);
            if (m == 2) expect_count();
            {sel, fast} = 2'h2;
            repeat (3) @(negedge ref_clk);
            chk("source slow", 2, src);
            chk("flag cleared", 0, flag);
            sel = 1'b0;
            @(negedge ref_clk);
            chk("switch holds", 0, exec);
            chk("status held", (m == 6) ? 4'h2 : 4'h4, status);
            if (m == 6) expect_bias();
            else expect_count();
        end
        // random settings against the combinational model
        repeat (24) begin
            @(negedge ref_clk);
            cfg = osc_ctrl_pkg::osc_mode_t'($urandom_range(7));
            {sel, fast, sec, wden} = 4'($urandom);
            @(negedge ref_clk);
            chk("gain", m_gain(cfg), gain);
            chk("source", sel ? (fast ? 1 : 2) : 0, src);
            chk("shared", cfg == 0 && sec, shared);
            chk("gpio", cfg == 3, gpio);
            chk("wd enable", wden && !wdr, wdce);
        end
        wrap_up();
    end
    // the whole run needs well under 3000 cycles
    initial begin
        #1_200_000;
        errors++;
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
